//--- src/astx_top.sv
// transmit side of the asynchronous serial interface with APB registers
// assumes one clock; the receiver proper lives elsewhere and gets the rx tick
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`default_nettype none
module astx_top (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RESET_N,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic PREADY,
  output logic [31:0] PRDATA,
  output logic PSLVERR,
  // serial pin and events
  output logic TX_OUT,
  output logic TX_OE,
  output logic IRQ,
  output logic RX_BAUD_TICK
);
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_DATA = 5'b00010,
    ST_IDLEFR = 5'b00100,
    ST_BREAK = 5'b01000,
    ST_EXTRA = 5'b10000
  } astx_state_t;

  astx_state_t state;
  astx_state_t next_state;
  astx_pkg::astx_ctrl_t ctrl;
  astx_pkg::astx_baud_t baud;
  logic [7:0] fine_tx;
  logic [7:0] fine_rx;
  logic word9;
  logic ninth_tx_bit;
  logic buffer_empty_flag;
  logic tx_finished_flag;
  logic status_seen;
  logic [8:0] tx_holding_buffer;
  logic hold_full;
  logic pending_idle;
  logic tx_on_q;
  logic [10:0] shreg;
  logic [3:0] bit_cnt;
  logic tx_tick;
  logic acc;
  logic wr;
  logic rd;
  logic wr_data;
  logic adv;
  logic direct;
  logic load_hold;
  logic set_fin;
  logic pin_en;
  logic [3:0] flen;
  logic [8:0] wdata9;

  // apb access completes in the first access cycle
  assign acc = PSEL & PENABLE & PREADY;
  assign wr = acc & PWRITE;
  assign rd = acc & ~PWRITE;
  assign wr_data = wr & (PADDR == astx_pkg::OFS_DATA);
  assign pin_en = ctrl.tx_on | ctrl.rx_on;
  assign flen = word9 ? astx_pkg::FRAME_LEN9 : astx_pkg::FRAME_LEN8;
  // an 8-bit frame sends its stop bit from the top slot, so that slot holds a one
  assign wdata9 = {ninth_tx_bit | ~word9, PWDATA[7:0]};
  // a frame ends on the tick that shifts out its last bit; while idle the sequencer advances every cycle
  assign adv = (state == ST_IDLE) | (tx_tick & (bit_cnt == 4'h1));

  // pick what the line carries next; break outranks everything but tx_on low
  always_comb begin
    next_state = ST_IDLE;
    load_hold = 1'b0;
    if (!ctrl.tx_on) begin
      next_state = ST_IDLE;
    end else if (ctrl.send_break_ctl) begin
      next_state = ST_BREAK;
    end else if (state == ST_BREAK) begin
      next_state = ST_EXTRA;
    end else if (pending_idle) begin
      next_state = ST_IDLEFR;
    end else if (hold_full) begin
      next_state = ST_DATA;
      load_hold = 1'b1;
    end
  end

  // direct load only when nothing else is owed to the line
  assign direct = wr_data & (state == ST_IDLE) & (next_state == ST_IDLE) & ctrl.tx_on;
  assign set_fin = adv & (state != ST_IDLE) & (next_state == ST_IDLE);

  // transmit generator, independent of the receive one
  astx_baud_gen #(.CW(24)) u_tx_baud (
    .clk(REF_CLK),
    .rst_n(RESET_N),
    .run(state != ST_IDLE),
    .coarse_sel(baud.coarse_divisor),
    .rate_sel(baud.tx_rate_div),
    .fine(fine_tx),
    .tick(tx_tick)
  );

  // receive generator, its tick handed to the receiver
  astx_baud_gen #(.CW(24)) u_rx_baud (
    .clk(REF_CLK),
    .rst_n(RESET_N),
    .run(ctrl.rx_on),
    .coarse_sel(baud.coarse_divisor),
    .rate_sel(baud.rx_rate_div),
    .fine(fine_rx),
    .tick(RX_BAUD_TICK)
  );

  // frame sequencer and shift register; shifts in ones behind the frame
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state <= ST_IDLE;
      shreg <= '1;
      bit_cnt <= 4'h0;
    end else if (direct) begin
      state <= ST_DATA;
      shreg <= {1'b1, wdata9, 1'b0};
      bit_cnt <= flen;
    end else if (adv) begin
      state <= next_state;
      case (next_state)
        ST_DATA: begin
          shreg <= {1'b1, tx_holding_buffer, 1'b0};
          bit_cnt <= flen;
        end
        ST_IDLEFR: begin
          shreg <= '1;
          bit_cnt <= flen;
        end
        ST_BREAK: begin
          shreg <= '0;
          bit_cnt <= flen;
        end
        ST_EXTRA: begin
          shreg <= '1;
          bit_cnt <= astx_pkg::EXTRA_LEN;
        end
        default: begin
          shreg <= '1;
          bit_cnt <= 4'h0;
        end
      endcase
    end else if (tx_tick) begin
      shreg <= {1'b1, shreg[10:1]};
      bit_cnt <= bit_cnt - 4'h1;
    end
  end

  // pin drive; bit_cnt ends an 8-bit frame before the trailing fill reaches the pin
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      TX_OUT <= 1'b1;
      TX_OE <= 1'b0;
    end else begin
      TX_OUT <= (state == ST_IDLE) ? 1'b1 : shreg[0];
      TX_OE <= pin_en;
    end
  end

  // holding buffer; dropping tx_on discards a queued word
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      tx_holding_buffer <= '0;
      hold_full <= 1'b0;
    end else if (!ctrl.tx_on) begin
      hold_full <= 1'b0;
    end else if (wr_data & ~direct) begin
      tx_holding_buffer <= wdata9;
      hold_full <= 1'b1;
    end else if (adv & load_hold) begin
      hold_full <= 1'b0;
    end
  end

  // idle frame owed after every rising edge of tx_on, set wins over use
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      tx_on_q <= 1'b0;
      pending_idle <= 1'b0;
    end else begin
      tx_on_q <= ctrl.tx_on;
      if (ctrl.tx_on & ~tx_on_q) begin
        pending_idle <= 1'b1;
      end else if (adv & (next_state == ST_IDLEFR)) begin
        pending_idle <= 1'b0;
      end
    end
  end

  // status flags: hardware set beats the read-then-write clear
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      buffer_empty_flag <= astx_pkg::RST_EMPTY;
      tx_finished_flag <= astx_pkg::RST_FINISHED;
      status_seen <= 1'b0;
    end else begin
      if (direct | (adv & load_hold)) begin
        buffer_empty_flag <= 1'b1;
      end else if (wr_data & status_seen) begin
        buffer_empty_flag <= 1'b0;
      end
      if (set_fin) begin
        tx_finished_flag <= 1'b1;
      end else if (wr_data & status_seen) begin
        tx_finished_flag <= 1'b0;
      end
      if (rd & (PADDR == astx_pkg::OFS_STATUS)) begin
        status_seen <= 1'b1;
      end else if (wr_data) begin
        status_seen <= 1'b0;
      end
    end
  end

  // single request line; cpu-level masking is the controller's job
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= (buffer_empty_flag & ctrl.empty_irq_en)
        | (tx_finished_flag & ctrl.finished_irq_en);
    end
  end

  // software-written configuration
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ctrl <= '0;
      baud <= '0;
      fine_tx <= astx_pkg::RST_BYTE;
      fine_rx <= astx_pkg::RST_BYTE;
      word9 <= 1'b0;
      ninth_tx_bit <= 1'b0;
    end else if (wr) begin
      case (PADDR)
        astx_pkg::OFS_CTRL1: begin
          ninth_tx_bit <= PWDATA[astx_pkg::BIT_NINTH];
          word9 <= PWDATA[astx_pkg::BIT_WORD9];
        end
        astx_pkg::OFS_CTRL2: ctrl <= PWDATA[7:0];
        astx_pkg::OFS_BAUD: baud <= PWDATA[7:0];
        astx_pkg::OFS_FINE_RX: fine_rx <= PWDATA[7:0];
        astx_pkg::OFS_FINE_TX: fine_tx <= PWDATA[7:0];
        default: ;
      endcase
    end
  end

  // read data and error latched in setup so they stand in the access cycle
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      PREADY <= 1'b0;
      PRDATA <= '0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= PSEL & ~PENABLE;
      PSLVERR <= 1'b0;
      PRDATA <= '0;
      if (PSEL & ~PENABLE) begin
        case (PADDR)
          astx_pkg::OFS_STATUS: begin
            PRDATA[astx_pkg::BIT_EMPTY] <= buffer_empty_flag;
            PRDATA[astx_pkg::BIT_FINISHED] <= tx_finished_flag;
          end
          astx_pkg::OFS_DATA: PRDATA <= '0;
          astx_pkg::OFS_CTRL1: begin
            PRDATA[astx_pkg::BIT_NINTH] <= ninth_tx_bit;
            PRDATA[astx_pkg::BIT_WORD9] <= word9;
          end
          astx_pkg::OFS_CTRL2: PRDATA[7:0] <= ctrl;
          astx_pkg::OFS_BAUD: PRDATA[7:0] <= baud;
          astx_pkg::OFS_FINE_RX: PRDATA[7:0] <= fine_rx;
          astx_pkg::OFS_FINE_TX: PRDATA[7:0] <= fine_tx;
          default: PSLVERR <= 1'b1;
        endcase
      end
    end
  end

  // checks on the driven behaviour
  property p_idle_high;
    @(posedge REF_CLK) disable iff (!RESET_N)
    (state == ST_IDLE) |=> TX_OUT;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("line low while idle");

  property p_release;
    @(posedge REF_CLK) disable iff (!RESET_N)
    !pin_en |=> !TX_OE;
  endproperty
  a_release: assert property (p_release) else $error("pin kept with both off");

  property p_start_low;
    @(posedge REF_CLK) disable iff (!RESET_N)
    direct |-> ##2 !TX_OUT;
  endproperty
  a_start_low: assert property (p_start_low) else $error("start bit not low");

  property p_frame_len;
    @(posedge REF_CLK) disable iff (!RESET_N)
    direct |=> (bit_cnt == (word9 ? 4'hB : 4'hA)) && (state == ST_DATA);
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("bad frame length");

  property p_direct_empty;
    @(posedge REF_CLK) disable iff (!RESET_N)
    direct |=> buffer_empty_flag && !hold_full;
  endproperty
  a_direct_empty: assert property (p_direct_empty) else $error("empty not set");

  property p_clear_seq;
    @(posedge REF_CLK) disable iff (!RESET_N)
    (wr_data && status_seen && !direct && !(adv && load_hold) && !set_fin)
      |=> !buffer_empty_flag && !tx_finished_flag;
  endproperty
  a_clear_seq: assert property (p_clear_seq) else $error("flags not cleared");

  property p_busy_hold;
    @(posedge REF_CLK) disable iff (!RESET_N)
    (wr_data && status_seen && state != ST_IDLE && ctrl.tx_on && !(adv && load_hold))
      |=> hold_full && !buffer_empty_flag;
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("write not held");

  property p_finish;
    @(posedge REF_CLK) disable iff (!RESET_N)
    set_fin |=> tx_finished_flag && (state == ST_IDLE);
  endproperty
  a_finish: assert property (p_finish) else $error("finished flag missed");

  property p_extra_bit;
    @(posedge REF_CLK) disable iff (!RESET_N)
    (state == ST_BREAK && adv && ctrl.tx_on && !ctrl.send_break_ctl)
      |=> (state == ST_EXTRA) ##1 TX_OUT;
  endproperty
  a_extra_bit: assert property (p_extra_bit) else $error("no high after break");

  property p_idle_owed;
    @(posedge REF_CLK) disable iff (!RESET_N)
    $rose(ctrl.tx_on) |=> pending_idle;
  endproperty
  a_idle_owed: assert property (p_idle_owed) else $error("idle frame not queued");

  property p_irq;
    @(posedge REF_CLK) disable iff (!RESET_N)
    (buffer_empty_flag && ctrl.empty_irq_en) |=> IRQ;
  endproperty
  a_irq: assert property (p_irq) else $error("request missing");
endmodule // astx_top
`default_nettype wire

//--- src/astx_pkg.sv
// constants, field layouts and shared types of the serial transmitter
// assumes an APB slave with 32-bit data and byte addresses in PADDR
// Function
// - enabled with nothing to send: serial output held high
// - both directions disabled: pin handed back to port function
// - frame is start bit, 8 or 9 data bits lsb first, stop bit
// - start bit driven low, stop bit driven high
// - word length select set: ninth bit comes from ninth_tx_bit
// - idle character is a whole frame of ones
// - break is whole frames of zeros, then one extra high bit
// - transmit and receive rates come from separate generators
// - setting tx_on queues one idle frame before data
// - status read then data write clears buffer_empty_flag
// - buffer_empty_flag set when holding buffer moves into shifter
// - write during a frame goes to holding buffer until frame ends
// - write while idle loads shifter directly and sets empty flag
// - tx_finished_flag set after the stop bit of a frame; here only when the sequencer then returns to ST_IDLE
// - tx_finished_flag cleared by the same read-then-write sequence
// - break repeats while send_break_ctl set, then one high bit
// - toggling tx_on mid-frame sends an idle frame after it
// - nonzero fine prescaler further divides; zero leaves it off
`default_nettype none
package astx_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_DATA = 8'h04;
  localparam logic [7:0] OFS_CTRL1 = 8'h08;
  localparam logic [7:0] OFS_CTRL2 = 8'h0C;
  localparam logic [7:0] OFS_BAUD = 8'h10;
  localparam logic [7:0] OFS_FINE_RX = 8'h14;
  localparam logic [7:0] OFS_FINE_TX = 8'h18;
  // field positions
  localparam int BIT_EMPTY = 7;
  localparam int BIT_FINISHED = 6;
  localparam int BIT_NINTH = 6;
  localparam int BIT_WORD9 = 4;
  // frame lengths in bit periods, and the oversampling factor
  localparam logic [3:0] FRAME_LEN8 = 4'hA;
  localparam logic [3:0] FRAME_LEN9 = 4'hB;
  localparam logic [3:0] EXTRA_LEN = 4'h1;
  localparam logic [4:0] OVERSAMPLE = 5'h10;
  // reset values
  localparam logic RST_EMPTY = 1'b1;
  localparam logic RST_FINISHED = 1'b1;
  localparam logic [7:0] RST_BYTE = 8'h00;

  // second control register, bit 7 down to bit 0
  typedef struct packed {
    logic empty_irq_en;
    logic finished_irq_en;
    logic [1:0] spare_hi;
    logic tx_on;
    logic rx_on;
    logic spare_lo;
    logic send_break_ctl;
  } astx_ctrl_t;

  // baud divider register layout
  typedef struct packed {
    logic [1:0] coarse_divisor;
    logic [2:0] tx_rate_div;
    logic [2:0] rx_rate_div;
  } astx_baud_t;

  // coarse divisor select to factor 1, 3, 4 or 13
  function automatic logic [3:0] coarse_factor(input logic [1:0] sel);
    case (sel)
      2'h0: coarse_factor = 4'h1;
      2'h1: coarse_factor = 4'h3;
      2'h2: coarse_factor = 4'h4;
      default: coarse_factor = 4'hD;
    endcase
  endfunction
endpackage
`default_nettype wire

//--- src/astx_baud_gen.sv
// bit-rate tick generator: one pulse per bit period
// assumes the divider settings stay stable while run is high
`default_nettype none
module astx_baud_gen #(
  parameter int CW = 24
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // settings
  input wire logic run,
  input wire logic [1:0] coarse_sel,
  input wire logic [2:0] rate_sel,
  input wire logic [7:0] fine,
  // bit tick
  output logic tick
);
  logic [CW-1:0] cnt;
  logic [CW-1:0] period;
  logic [7:0] fine_eff;

  // zero fine value bypasses the prescaler
  always_comb begin
    fine_eff = (fine == 8'h00) ? 8'h01 : fine;
    period = CW'(astx_pkg::coarse_factor(coarse_sel)) * (CW'(1) << rate_sel)
      * CW'(fine_eff) * CW'(astx_pkg::OVERSAMPLE);
  end

  // counter restarts at one whenever run drops: the tick flop lags the counter
  // by a cycle, so starting at one keeps the first bit of a frame one full period
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
      tick <= 1'b0;
    end else if (!run) begin
      cnt <= CW'(1);
      tick <= 1'b0;
    end else if (cnt == period - CW'(1)) begin
      cnt <= '0;
      tick <= 1'b1;
    end else begin
      cnt <= cnt + CW'(1);
      tick <= 1'b0;
    end
  end
endmodule // astx_baud_gen
`default_nettype wire

//--- test/astx_line_model.sv
// far-end receiver model: watches the serial line and collects words
// assumes the bench sets word length and bit period before each frame
`default_nettype none
module astx_line_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // line and format
  input wire logic line,
  input wire logic oe,
  input wire logic nine,
  input wire logic [15:0] bit_len
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] words[$];
  int starts[$];
  int bad_stop = 0;
  int cyc = 0;
  int cnt;
  int k;
  logic busy;
  logic prev;
  logic [8:0] sh;
  // mid-bit sampling; a low stop bit counts as a broken frame, and the model
  // re-arms only on a falling edge, so a long break shows as one frame
  always @(posedge clk) begin
    if (!rst_n) begin
      busy = 1'b0;
      prev = 1'b1;
    end else begin
      cyc = cyc + 1;
      if (!busy && oe && prev && !line) begin
        busy = 1'b1;
        cnt = 0;
        sh = 9'h000;
        starts.push_back(cyc);
      end else if (busy) begin
        cnt = cnt + 1;
        if (cnt % bit_len == bit_len / 2) begin
          k = cnt / bit_len;
          if (k == 0) begin
            if (line) begin
              bad_stop = bad_stop + 1;
              busy = 1'b0;
            end
          end else if (k <= (nine ? 9 : 8)) begin
            sh[k - 1] = line;
          end else begin
            if (line) words.push_back(sh);
            else bad_stop = bad_stop + 1;
            busy = 1'b0;
          end
        end
      end
      prev = line;
    end
  end
endmodule // astx_line_model
`default_nettype wire

//--- test/tb_top.sv
// self-checking bench for the serial transmitter: registers, frames, flags, break
// assumes the far-end model and an apb slave that answers in the first access cycle
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rexp;
    logic err;
  } astx_row_t;
  localparam int LIMIT = 12000;
  localparam logic [7:0] A_ST = astx_pkg::OFS_STATUS;
  localparam logic [7:0] A_DT = astx_pkg::OFS_DATA;
  localparam logic [7:0] A_C1 = astx_pkg::OFS_CTRL1;
  localparam logic [7:0] A_C2 = astx_pkg::OFS_CTRL2;
  localparam logic [7:0] A_BD = astx_pkg::OFS_BAUD;
  localparam logic [7:0] A_FR = astx_pkg::OFS_FINE_RX;
  localparam logic [7:0] A_FT = astx_pkg::OFS_FINE_TX;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic [31:0] rdata;
  logic pready, pslverr, tx_out, tx_oe, irq, rx_tick, rerr;
  logic nine = 1'b0;
  logic prev_tx = 1'b1;
  logic [15:0] bit_len = 16'h0010;
  int run = 0, last_low = 0, last_high = 0, cyc = 0, fails = 0, compares = 0, t0, i;
  // register cases, one unmapped address among them: write, then read back; the last rows restore zero
  astx_row_t rows [12] = '{'{A_C1, 8'h50, 8'h50, 1'b0}, '{A_C2, 8'h32, 8'h32, 1'b0},
    '{A_BD, 8'hFF, 8'hFF, 1'b0}, '{A_FR, 8'hA5, 8'hA5, 1'b0}, '{A_FT, 8'h5A, 8'h5A, 1'b0},
    '{A_DT, 8'h11, 8'h00, 1'b0}, '{8'h1C, 8'h99, 8'h00, 1'b1}, '{A_C1, 8'h00, 8'h00, 1'b0},
    '{A_C2, 8'h00, 8'h00, 1'b0}, '{A_BD, 8'h00, 8'h00, 1'b0}, '{A_FR, 8'h00, 8'h00, 1'b0},
    '{A_FT, 8'h00, 8'h00, 1'b0}};

  astx_top dut (.REF_CLK(ref_clk), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata),
    .PSLVERR(pslverr), .TX_OUT(tx_out), .TX_OE(tx_oe), .IRQ(irq), .RX_BAUD_TICK(rx_tick));
  astx_line_model line (.clk(ref_clk), .rst_n(reset_n), .line(tx_out), .oe(tx_oe),
    .nine(nine), .bit_len(bit_len));

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  // hang limit, and run lengths of each line level for break timing
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (tx_out === prev_tx) run <= run + 1;
    else begin
      run <= 1;
      if (prev_tx === 1'b0) last_low <= run;
      else last_high <= run;
    end
    prev_tx <= tx_out;
    if (cyc >= LIMIT) begin
      fails = fails + 1;
      $display("[FAIL] cycle limit expected %0d seen %0d", LIMIT, cyc);
      conclude();
    end
  end

  task automatic conclude();
    if (fails == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares = compares + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chk1(input string nm, input logic exp, input logic got);
    chk(nm, {31'h0, exp}, {31'h0, got});
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // one transfer, one idle edge after the previous release; the request holds until pready
  // no wait count of its own: a slave that never answers runs into the cycle limit
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e, input string nm);
    apb(1'b0, a, 8'h00);
    chk(nm, {24'h000000, e}, rdata & {24'hFFFFFF, m});
  endtask
  task automatic get_word(input logic [8:0] e, input string nm);
    int n;
    n = 0;
    while (line.words.size() == 0 && n < 5000) begin
      @(posedge ref_clk);
      n = n + 1;
    end
    if (line.words.size() == 0) chk(nm, {23'h0, e}, 32'hFFFFFFFF);
    else chk(nm, {23'h0, e}, {23'h0, line.words.pop_front()});
  endtask
  task automatic wait_tx(input logic lvl);
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n = n + 1;
    end while (tx_out !== lvl && n < 3000);
    chk1("line level", lvl, tx_out);
  endtask
  task automatic wait_tick();
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n = n + 1;
    end while (rx_tick !== 1'b1 && n < 500);
    chk1("rx tick seen", 1'b1, rx_tick);
  endtask

  initial begin
    idle(6);
    chk1("TX_OUT in reset", 1'b1, tx_out);
    chk1("TX_OE in reset", 1'b0, tx_oe);
    chk1("IRQ in reset", 1'b0, irq);
    idle(6);
    reset_n <= 1'b1;
    rd(A_ST, 8'hFF, 8'hC0, "STATUS reset");
    for (i = 0; i < 12; i++) begin
      wr(rows[i].addr, rows[i].wdata);
      chk1("write err", rows[i].err, rerr);
      rd(rows[i].addr, 8'hFF, rows[i].rexp, "readback");
      chk1("read err", rows[i].err, rerr);
    end
    // enable: one idle frame goes ahead of the held word
    line.starts.delete();
    wr(A_C2, 8'h08);
    t0 = line.cyc;
    idle(2);
    chk1("TX_OE on", 1'b1, tx_oe);
    chk1("TX_OUT idle", 1'b1, tx_out);
    rd(A_ST, 8'h00, 8'h00, "STATUS");
    wr(A_DT, 8'hA5);
    rd(A_ST, 8'hFF, 8'h00, "STATUS cleared");
    while (line.starts.size() == 0 && line.cyc - t0 < 3000) idle(1);
    chk1("idle ahead", 1'b1, (line.starts[0] - t0) >= 160);
    rd(A_ST, 8'h80, 8'h80, "STATUS empty");
    get_word(9'h0A5, "word A5");
    idle(24);
    rd(A_ST, 8'hFF, 8'hC0, "STATUS done");
    // 9-bit words back to back: direct load, then holding buffer
    wr(A_C1, 8'h50);
    nine <= 1'b1;
    line.starts.delete();
    rd(A_ST, 8'h00, 8'h00, "STATUS");
    wr(A_DT, 8'h3C);
    rd(A_ST, 8'hFF, 8'h80, "STATUS direct");
    wr(A_DT, 8'h81);
    rd(A_ST, 8'hFF, 8'h00, "STATUS held");
    get_word(9'h13C, "nine bit A");
    get_word(9'h181, "nine bit B");
    chk("frame spacing", 32'h000000B0, line.starts[1] - line.starts[0]);
    // interrupt follows the enabled flags
    idle(24);
    wr(A_C1, 8'h00);
    nine <= 1'b0;
    wr(A_C2, 8'h48);
    idle(3);
    chk1("IRQ finished", 1'b1, irq);
    rd(A_ST, 8'h00, 8'h00, "STATUS");
    wr(A_DT, 8'h0F);
    idle(3);
    chk1("IRQ cleared", 1'b0, irq);
    get_word(9'h00F, "word 0F");
    idle(24);
    chk1("IRQ end", 1'b1, irq);
    wr(A_C2, 8'h88);
    idle(3);
    chk1("IRQ empty", 1'b1, irq);
    wr(A_C2, 8'h08);
    idle(3);
    chk1("IRQ masked", 1'b0, irq);
    // break frames while the control is set, then one high bit before the held word
    wr(A_C2, 8'h09);
    wait_tx(1'b0);
    idle(400);
    wr(A_C2, 8'h08);
    rd(A_ST, 8'h00, 8'h00, "STATUS");
    wr(A_DT, 8'h5A);
    wait_tx(1'b1);
    idle(1);
    chk("break whole frames", 32'h00000000, last_low % 160);
    chk1("break repeats", 1'b1, last_low >= 320);
    wait_tx(1'b0);
    idle(1);
    chk("extra high bit", 32'h00000010, last_high);
    get_word(9'h05A, "after break");
    // enable toggled mid-frame: idle frame after the current word
    idle(24);
    line.starts.delete();
    rd(A_ST, 8'h00, 8'h00, "STATUS");
    wr(A_DT, 8'h55);
    wr(A_C2, 8'h00);
    wr(A_C2, 8'h08);
    rd(A_ST, 8'h00, 8'h00, "STATUS");
    wr(A_DT, 8'h66);
    get_word(9'h055, "word 55");
    get_word(9'h066, "word 66");
    chk("idle after word", 32'h00000140, line.starts[1] - line.starts[0]);
    // reset in mid-frame
    idle(24);
    rd(A_ST, 8'h00, 8'h00, "STATUS");
    wr(A_DT, 8'h77);
    idle(40);
    reset_n <= 1'b0;
    idle(2);
    chk1("TX_OUT mid reset", 1'b1, tx_out);
    chk1("TX_OE mid reset", 1'b0, tx_oe);
    idle(2);
    reset_n <= 1'b1;
    rd(A_ST, 8'hFF, 8'hC0, "STATUS again");
    rd(A_C2, 8'hFF, 8'h00, "CTRL2 again");
    // divided transmit rate beside an independent receive tick
    wr(A_BD, 8'h48);
    wr(A_FT, 8'h02);
    bit_len <= 16'h00C0;
    wr(A_C2, 8'h0C);
    wait_tick();
    t0 = cyc;
    idle(1);
    wait_tick();
    chk("rx tick period", 32'h00000030, cyc - t0);
    rd(A_ST, 8'h00, 8'h00, "STATUS");
    wr(A_DT, 8'hC3);
    get_word(9'h0C3, "slow word");
    chk("broken frames", 32'h00000001, line.bad_stop);
    conclude();
  end
endmodule // tb_top
`default_nettype wire
